//--- design/smsf_map.svh
// smsf_map.svh: offsets-free constant map of the slave mode stream fifo
// assumes: included by its bare name, definitions only
`ifndef SMSF_MAP_SVH
`define SMSF_MAP_SVH

`define SMSF_BLOCK_BYTES  8'h40
`define SMSF_IN_DEPTH     8'h80
`define SMSF_OUT_DEPTH    8
`define SMSF_BYTE_W       8
`define SMSF_FILL_BYTE    8'h00
`define SMSF_GC_ADDR      7'h00
`define SMSF_CLK_HZ       100000000
`define SMSF_UART_BAUD    115200
`define SMSF_UART_DIV     12'((`SMSF_CLK_HZ) / (`SMSF_UART_BAUD))
`define SMSF_UART_HALF    12'((`SMSF_CLK_HZ) / (2 * (`SMSF_UART_BAUD)))
`define SMSF_SYNC_RST     6'h3c

`endif

//--- design/smsf_pkg.sv
// smsf_pkg: types of the slave mode stream fifo
// assumes: constants live in smsf_map.svh
package smsf_pkg;

    typedef enum logic [1:0] {
        SMSF_SEL_SPI  = 2'h0,
        SMSF_SEL_I2C  = 2'h1,
        SMSF_SEL_UART = 2'h3
    } smsf_sel_t;

    typedef enum logic [2:0] {
        SMSF_I2C_IDLE = 3'h0,
        SMSF_I2C_ADDR = 3'h1,
        SMSF_I2C_ACKA = 3'h3,
        SMSF_I2C_RX   = 3'h2,
        SMSF_I2C_ACKR = 3'h6,
        SMSF_I2C_TX   = 3'h7,
        SMSF_I2C_ACKT = 3'h5
    } smsf_i2c_st_t;

    typedef struct packed {
        smsf_sel_t  sel;
        logic       read_full;
        logic [6:0] i2c_addr;
        logic       i2c_gc_en;
    } smsf_cfg_t;

endpackage : smsf_pkg

//--- design/smsf_fifo.sv
// smsf_fifo: outbound byte fifo, parameterised width and depth
// assumes: single clock, synchronous active-high reset, clear empties it
`timescale 1ns/100ps
`default_nettype none

module smsf_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         clk_in,
    input  wire logic         reset_in,
    input  wire logic         clear_in,
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;
    logic          push;
    logic          pop;

    assign in_ready_out  = (cnt_r != (AW+1)'(D));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out  = mem_r[rp_r];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    chk_fifo_bounds: assert property (@(posedge clk_in) disable iff (reset_in)
        cnt_r <= (AW+1)'(D))
        else $error("outbound fifo count beyond depth");

endmodule : smsf_fifo

`default_nettype wire

//--- design/smsf_top.sv
// smsf_top: host byte port, outbound and inbound buffers, spi/i2c/uart slave engines
// assumes: clk_in 100 MHz, spi_sck_in from the external master, i2c, uart and select pins pass sync flops
//
// Contract
// - exactly one engine, picked by the select setting, moves bytes to and from the buffers.
// - clear empties both the inbound and outbound buffers and the spi hold byte; bytes already in the uart or i2c shifters still go out.
// - in full-read mode the host only sees inbound data as whole 64-byte blocks.
// - the spi engine shifts outbound bytes to the master in write order.
// - the spi engine stores each byte from the master into the inbound buffer in order.
// - with spi selected and target select low the spi engine drives miso and all else stays input.
// - with target select high the spi engine is passive and miso is released.
// - the i2c engine answers its configured address, and the general call too when enabled, flags set before attach.
// - the i2c engine has no sub-address; writes go inbound, reads come outbound.
// - the i2c engine returns outbound bytes in write order to a reading master.
`include "smsf_map.svh"
`timescale 1ns/100ps
`default_nettype none

module smsf_top (
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    input  wire smsf_pkg::smsf_cfg_t cfg_in,
    input  wire logic                clear_in,
    input  wire logic                host_wr_valid_in,
    input  wire logic [7:0]          host_wr_data_in,
    output logic                     host_wr_ready_out,
    output logic                     host_rd_valid_out,
    output logic [7:0]               host_rd_data_out,
    input  wire logic                host_rd_ready_in,
    output logic                     in_overflow_out,
    input  wire logic                spi_sck_in,
    input  wire logic                spi_mosi_in,
    input  wire logic                target_select_in,
    output logic                     spi_miso_out,
    output logic                     spi_miso_oe_out,
    input  wire logic                i2c_scl_in,
    input  wire logic                i2c_sda_in,
    output logic                     i2c_sda_out,
    output logic                     i2c_sda_oe_out,
    input  wire logic                uart_rx_in,
    output logic                     uart_tx_out
);
    // outbound buffer
    logic       out_valid;
    logic [7:0] out_data;
    logic       out_pop;
    logic       spi_pop;
    logic       i2c_pop;
    logic       uart_pop;
    logic       sel_spi;
    logic       sel_i2c;
    logic       sel_uart;

    assign sel_spi  = (cfg_in.sel == smsf_pkg::SMSF_SEL_SPI);
    assign sel_i2c  = (cfg_in.sel == smsf_pkg::SMSF_SEL_I2C);
    assign sel_uart = (cfg_in.sel == smsf_pkg::SMSF_SEL_UART);
    assign out_pop  = spi_pop || i2c_pop || uart_pop;

    smsf_fifo #(.W(`SMSF_BYTE_W), .D(`SMSF_OUT_DEPTH)) u_out_fifo (
        .clk_in        (clk_in),
        .reset_in      (reset_in),
        .clear_in      (clear_in),
        .in_valid_in   (host_wr_valid_in),
        .in_data_in    (host_wr_data_in),
        .in_ready_out  (host_wr_ready_out),
        .out_valid_out (out_valid),
        .out_data_out  (out_data),
        .out_ready_in  (out_pop)
    );

    // pin and cross-domain synchronisers: 0 rx tgl, 1 ack tgl, 2 ss, 3 scl, 4 sda, 5 rx
    logic [5:0] sync_raw;
    logic [5:0] sync_q1_r;
    logic [5:0] sync_q2_r;
    logic       spi_rx_tgl_r;
    logic       spi_ack_tgl_r;

    assign sync_raw = {uart_rx_in, i2c_sda_in, i2c_scl_in, target_select_in,
                       spi_ack_tgl_r, spi_rx_tgl_r};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge clk_in) begin
                if (reset_in) begin
                    sync_q1_r[gi] <= 1'(`SMSF_SYNC_RST >> gi);
                    sync_q2_r[gi] <= 1'(`SMSF_SYNC_RST >> gi);
                end else begin
                    sync_q1_r[gi] <= sync_raw[gi];
                    sync_q2_r[gi] <= sync_q1_r[gi];
                end
            end
        end
    endgenerate

    logic ss_idle;
    assign ss_idle = sync_q2_r[2];

    // spi link domain, bit counter and shifter cleared while target select is high
    logic [2:0] spi_bit_r;
    logic [6:0] spi_sh_r;
    logic [7:0] spi_rx_byte_r;
    logic [7:0] spi_hold_r;

    always_ff @(posedge spi_sck_in or posedge target_select_in) begin
        if (target_select_in) begin
            spi_bit_r <= 3'h0;
            spi_sh_r  <= 7'h00;
        end else begin
            spi_bit_r <= spi_bit_r + 3'h1;
            spi_sh_r  <= {spi_sh_r[5:0], spi_mosi_in};
        end
    end

    always_ff @(posedge spi_sck_in or posedge reset_in) begin
        if (reset_in) begin
            spi_rx_tgl_r  <= 1'b0;
            spi_ack_tgl_r <= 1'b0;
            spi_rx_byte_r <= 8'h00;
        end else if (spi_bit_r == 3'h7) begin
            spi_rx_byte_r <= {spi_sh_r, spi_mosi_in};
            spi_rx_tgl_r  <= ~spi_rx_tgl_r;
            spi_ack_tgl_r <= ~spi_ack_tgl_r;
        end
    end

    // hold byte is static between ack toggles, so the link side may read it
    assign spi_miso_out    = spi_hold_r[~spi_bit_r];
    assign spi_miso_oe_out = sel_spi && !target_select_in;

    // spi system side
    logic spi_rx_seen_r;
    logic spi_ack_seen_r;
    logic spi_fill_r;
    logic spi_rx_evt;
    logic spi_ack_evt;
    logic spi_load;

    assign spi_rx_evt  = (sync_q2_r[0] != spi_rx_seen_r) && sel_spi;
    assign spi_ack_evt = (sync_q2_r[1] != spi_ack_seen_r);
    assign spi_load    = sel_spi && (spi_ack_evt || (spi_fill_r && ss_idle));
    assign spi_pop     = spi_load && out_valid;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            spi_rx_seen_r  <= 1'b0;
            spi_ack_seen_r <= 1'b0;
        end else begin
            spi_rx_seen_r  <= sync_q2_r[0];
            spi_ack_seen_r <= sync_q2_r[1];
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            spi_hold_r <= `SMSF_FILL_BYTE;
            spi_fill_r <= 1'b1;
        end else if (spi_load) begin
            spi_hold_r <= out_valid ? out_data : `SMSF_FILL_BYTE;
            spi_fill_r <= !out_valid;
        end
    end

    // i2c slave engine, sampled pins
    smsf_pkg::smsf_i2c_st_t i2c_st_r;
    logic       scl_prev_r;
    logic       sda_prev_r;
    logic [7:0] i2c_sh_r;
    logic [3:0] i2c_cnt_r;
    logic       i2c_rw_r;
    logic       i2c_nack_r;
    logic       i2c_low_r;
    logic       i2c_push;
    logic [6:0] i2c_addr_r;
    logic       i2c_gc_r;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       i2c_start;
    logic       i2c_stop;
    logic       addr_hit;
    logic       i2c_load;

    assign scl_s     = sync_q2_r[3];
    assign sda_s     = sync_q2_r[4];
    assign scl_rise  = scl_s && !scl_prev_r;
    assign scl_fall  = !scl_s && scl_prev_r;
    assign i2c_start = scl_s && scl_prev_r && sda_prev_r && !sda_s;
    assign i2c_stop  = scl_s && scl_prev_r && !sda_prev_r && sda_s;
    assign addr_hit  = (i2c_sh_r[7:1] == i2c_addr_r) ||
                       (i2c_gc_r && i2c_sh_r == {`SMSF_GC_ADDR, 1'b0});
    assign i2c_load  = scl_fall && i2c_rw_r &&
                       ((i2c_st_r == smsf_pkg::SMSF_I2C_ACKA) ||
                        (i2c_st_r == smsf_pkg::SMSF_I2C_ACKT && !i2c_nack_r));
    assign i2c_pop   = sel_i2c && i2c_load && out_valid;
    assign i2c_push  = sel_i2c && scl_fall && (i2c_st_r == smsf_pkg::SMSF_I2C_RX) &&
                       (i2c_cnt_r == 4'h8);
    assign i2c_sda_out    = 1'b0;
    assign i2c_sda_oe_out = i2c_low_r;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_prev_r <= scl_s;
            sda_prev_r <= sda_s;
        end
    end

    // address and flags are taken only while the engine is idle
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            i2c_addr_r <= 7'h00;
            i2c_gc_r   <= 1'b0;
        end else if (i2c_st_r == smsf_pkg::SMSF_I2C_IDLE) begin
            i2c_addr_r <= cfg_in.i2c_addr;
            i2c_gc_r   <= cfg_in.i2c_gc_en;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || !sel_i2c || i2c_stop) begin
            i2c_st_r  <= smsf_pkg::SMSF_I2C_IDLE;
            i2c_cnt_r <= 4'h0;
            i2c_low_r <= 1'b0;
        end else if (i2c_start) begin
            i2c_st_r  <= smsf_pkg::SMSF_I2C_ADDR;
            i2c_cnt_r <= 4'h0;
            i2c_low_r <= 1'b0;
        end else begin
            case (i2c_st_r)
                smsf_pkg::SMSF_I2C_ADDR, smsf_pkg::SMSF_I2C_RX: begin
                    if (scl_rise) begin
                        i2c_sh_r  <= {i2c_sh_r[6:0], sda_s};
                        i2c_cnt_r <= i2c_cnt_r + 4'h1;
                    end else if (scl_fall && i2c_cnt_r == 4'h8) begin
                        i2c_cnt_r <= 4'h0;
                        if (i2c_st_r == smsf_pkg::SMSF_I2C_RX) begin
                            i2c_low_r <= 1'b1;
                            i2c_st_r  <= smsf_pkg::SMSF_I2C_ACKR;
                        end else if (addr_hit) begin
                            i2c_rw_r  <= i2c_sh_r[0];
                            i2c_low_r <= 1'b1;
                            i2c_st_r  <= smsf_pkg::SMSF_I2C_ACKA;
                        end else begin
                            i2c_st_r  <= smsf_pkg::SMSF_I2C_IDLE;
                        end
                    end
                end
                smsf_pkg::SMSF_I2C_ACKA, smsf_pkg::SMSF_I2C_ACKT: begin
                    if (scl_rise) begin
                        i2c_nack_r <= sda_s;
                    end else if (i2c_load) begin
                        i2c_sh_r  <= out_valid ? out_data : `SMSF_FILL_BYTE;
                        i2c_low_r <= out_valid ? !out_data[7] : 1'b1;
                        i2c_cnt_r <= 4'h1;
                        i2c_st_r  <= smsf_pkg::SMSF_I2C_TX;
                    end else if (scl_fall) begin
                        i2c_low_r <= 1'b0;
                        i2c_st_r  <= (i2c_st_r == smsf_pkg::SMSF_I2C_ACKA) ?
                                     smsf_pkg::SMSF_I2C_RX : smsf_pkg::SMSF_I2C_IDLE;
                    end
                end
                smsf_pkg::SMSF_I2C_ACKR: begin
                    if (scl_fall) begin
                        i2c_low_r <= 1'b0;
                        i2c_st_r  <= smsf_pkg::SMSF_I2C_RX;
                    end
                end
                smsf_pkg::SMSF_I2C_TX: begin
                    if (scl_fall && i2c_cnt_r == 4'h8) begin
                        i2c_low_r <= 1'b0;
                        i2c_st_r  <= smsf_pkg::SMSF_I2C_ACKT;
                    end else if (scl_fall) begin
                        i2c_sh_r  <= {i2c_sh_r[6:0], 1'b0};
                        i2c_low_r <= !i2c_sh_r[6];
                        i2c_cnt_r <= i2c_cnt_r + 4'h1;
                    end
                end
                default: begin
                    i2c_low_r <= 1'b0;
                end
            endcase
        end
    end

    // uart 8n1
    logic [11:0] utx_div_r;
    logic [3:0]  utx_bits_r;
    logic [9:0]  utx_sh_r;
    logic [11:0] urx_div_r;
    logic [3:0]  urx_bits_r;
    logic [7:0]  urx_sh_r;
    logic        urx_busy_r;
    logic        urx_push;

    assign uart_pop    = sel_uart && (utx_bits_r == 4'h0) && out_valid;
    assign uart_tx_out = utx_sh_r[0];
    assign urx_push    = sel_uart && urx_busy_r && (urx_div_r == 12'h000) &&
                         (urx_bits_r == 4'h9);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            utx_sh_r   <= 10'h3ff;
            utx_bits_r <= 4'h0;
            utx_div_r  <= 12'h000;
        end else if (uart_pop) begin
            utx_sh_r   <= {1'b1, out_data, 1'b0};
            utx_bits_r <= 4'ha;
            utx_div_r  <= `SMSF_UART_DIV;
        end else if (utx_bits_r != 4'h0) begin
            if (utx_div_r == 12'h001) begin
                utx_sh_r   <= {1'b1, utx_sh_r[9:1]};
                utx_bits_r <= utx_bits_r - 4'h1;
                utx_div_r  <= `SMSF_UART_DIV;
            end else begin
                utx_div_r  <= utx_div_r - 12'h001;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || !sel_uart) begin
            urx_busy_r <= 1'b0;
            urx_bits_r <= 4'h0;
            urx_div_r  <= 12'h000;
        end else if (!urx_busy_r) begin
            if (!sync_q2_r[5]) begin
                urx_busy_r <= 1'b1;
                urx_bits_r <= 4'h0;
                urx_div_r  <= `SMSF_UART_HALF;
            end
        end else if (urx_div_r != 12'h000) begin
            urx_div_r <= urx_div_r - 12'h001;
        end else begin
            urx_div_r  <= `SMSF_UART_DIV;
            urx_bits_r <= urx_bits_r + 4'h1;
            if (urx_bits_r == 4'h0 && sync_q2_r[5]) begin
                urx_busy_r <= 1'b0;
            end else if (urx_bits_r == 4'h9) begin
                urx_busy_r <= 1'b0;
            end else if (urx_bits_r != 4'h0) begin
                urx_sh_r <= {sync_q2_r[5], urx_sh_r[7:1]};
            end
        end
    end

    // inbound buffer, room for two whole blocks
    logic [7:0] in_mem_r [`SMSF_IN_DEPTH];
    logic [6:0] in_wp_r;
    logic [6:0] in_rp_r;
    logic [7:0] in_cnt_r;
    logic [7:0] blk_left_r;
    logic       in_push;
    logic [7:0] in_byte;
    logic       in_room;
    logic       in_pop;

    always_comb begin
        in_push = 1'b1;
        in_byte = spi_rx_byte_r;
        if (spi_rx_evt) begin
            in_byte = spi_rx_byte_r;
        end else if (i2c_push) begin
            in_byte = i2c_sh_r;
        end else if (urx_push) begin
            in_byte = urx_sh_r;
        end else begin
            in_push = 1'b0;
        end
    end

    assign in_room           = (in_cnt_r != `SMSF_IN_DEPTH);
    assign host_rd_valid_out = cfg_in.read_full ? (blk_left_r != 8'h00)
                                                : (in_cnt_r != 8'h00);
    assign host_rd_data_out  = in_mem_r[in_rp_r];
    assign in_pop            = host_rd_valid_out && host_rd_ready_in;

    always_ff @(posedge clk_in) begin
        if (in_push && in_room) begin
            in_mem_r[in_wp_r] <= in_byte;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            in_wp_r  <= 7'h00;
            in_rp_r  <= 7'h00;
            in_cnt_r <= 8'h00;
        end else begin
            if (in_push && in_room) begin
                in_wp_r <= in_wp_r + 7'h01;
            end
            if (in_pop) begin
                in_rp_r <= in_rp_r + 7'h01;
            end
            in_cnt_r <= in_cnt_r + 8'(in_push && in_room) - 8'(in_pop);
        end
    end

    // bytes still released from the current whole block
    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in || !cfg_in.read_full) begin
            blk_left_r <= 8'h00;
        end else if (in_pop) begin
            blk_left_r <= blk_left_r - 8'h01;
        end else if (blk_left_r == 8'h00 && in_cnt_r >= `SMSF_BLOCK_BYTES) begin
            blk_left_r <= `SMSF_BLOCK_BYTES;
        end
    end

    // sticky, dropped bytes are lost; only clear or reset takes it down
    always_ff @(posedge clk_in) begin
        if (reset_in || clear_in) begin
            in_overflow_out <= 1'b0;
        end else if (in_push && !in_room) begin
            in_overflow_out <= 1'b1;
        end
    end

    chk_engine_one: assert property (@(posedge clk_in) disable iff (reset_in)
        $onehot0({spi_pop, i2c_pop, uart_pop}))
        else $error("more than one engine popped the outbound buffer");

    chk_clear_empties: assert property (@(posedge clk_in) disable iff (reset_in)
        clear_in |=> (in_cnt_r == 8'h00) && !out_valid && !host_rd_valid_out)
        else $error("clear left bytes in a buffer");

    chk_full_block: assert property (@(posedge clk_in) disable iff (reset_in)
        (cfg_in.read_full && $rose(host_rd_valid_out)) |-> blk_left_r == `SMSF_BLOCK_BYTES)
        else $error("partial block released in full-read mode");

    chk_spi_order: assert property (@(posedge clk_in) disable iff (reset_in)
        (spi_pop && !clear_in) |=> spi_hold_r == $past(out_data) && !spi_fill_r)
        else $error("spi hold byte not taken from the outbound head");

    chk_spi_rx_push: assert property (@(posedge clk_in) disable iff (reset_in)
        (spi_rx_evt && in_room && !in_pop && !clear_in) |=>
            in_cnt_r == $past(in_cnt_r) + 8'h01)
        else $error("spi byte not stored inbound");

    chk_miso_drive: assert property (@(posedge clk_in) disable iff (reset_in)
        (sel_spi && !target_select_in) |-> spi_miso_oe_out)
        else $error("miso not driven while selected");

    chk_miso_release: assert property (@(posedge clk_in) disable iff (reset_in)
        target_select_in |-> !spi_miso_oe_out)
        else $error("miso driven while deselected");

    chk_i2c_addr: assert property (@(posedge clk_in) disable iff (reset_in)
        (i2c_st_r == smsf_pkg::SMSF_I2C_ACKA && $past(i2c_st_r) == smsf_pkg::SMSF_I2C_ADDR)
            |-> $past(addr_hit) && i2c_low_r)
        else $error("i2c acknowledged a foreign address");

    chk_i2c_tx_head: assert property (@(posedge clk_in) disable iff (reset_in)
        (i2c_pop && !clear_in) |=> i2c_sh_r == $past(out_data) &&
            i2c_st_r == smsf_pkg::SMSF_I2C_TX)
        else $error("i2c read byte not from outbound head");

    chk_fill_zero: assert property (@(posedge clk_in) disable iff (reset_in)
        (spi_load && !out_valid && !clear_in) |=> spi_hold_r == `SMSF_FILL_BYTE && spi_fill_r)
        else $error("empty outbound buffer did not yield zero");

endmodule : smsf_top

`default_nettype wire

//--- verif/smsf_spi_master.sv
// smsf_spi_master: behavioural spi master, mode 0, msb first
// assumes: select active low, sck stands low outside frames
`timescale 1ns/100ps
`default_nettype none
module smsf_spi_master (
    output logic      sck_out,
    output logic      mosi_out,
    output logic      select_n_out,
    input  wire logic miso_in
);
    initial begin
        sck_out      = 1'b0;
        mosi_out     = 1'b0;
        select_n_out = 1'b0;
        // a rising select clears the slave bit counter before the first frame
        #2 select_n_out = 1'b1;
    end
    task automatic set_select(input logic active);
        select_n_out = ~active;
        #100;
    endtask : set_select
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_out = tx[i];
            #24 sck_out = 1'b1;
            rx[i] = miso_in;
            #24 sck_out = 1'b0;
        end
        // a released line shows the inverse of its last bit
        mosi_out = ~tx[0];
        #200;
    endtask : xfer
endmodule : smsf_spi_master
`default_nettype wire

//--- verif/tb_top.sv
// tb_top: self-checking bench of the stream fifo: spi, i2c and uart loopback
// assumes: smsf_top and smsf_spi_master compiled before it
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic                clk_in = 1'b0;
    logic                sck, mosi, sel_n, miso, oe, wr_r, rd_v, ovf, sda_oe, utx;
    logic                rst = 1'b0, clr = 1'b0, wr_v = 1'b0, rd_r = 1'b0;
    logic                scl = 1'b1, sda_m = 1'b1;
    logic [8:0]          s;
    wire logic           sda;
    assign sda = sda_m & ~sda_oe;
    logic [7:0]          wr_d = 8'h00, rd_d, rx;
    smsf_pkg::smsf_cfg_t cfg = '{smsf_pkg::SMSF_SEL_SPI, 1'b0, 7'h00, 1'b0};
    int                  err_total = 0, checks_done = 0, cycles = 0;
    always #5 clk_in = ~clk_in;
    smsf_top i_dut (.clk_in(clk_in), .reset_in(rst), .cfg_in(cfg), .clear_in(clr),
        .host_wr_valid_in(wr_v), .host_wr_data_in(wr_d), .host_wr_ready_out(wr_r),
        .host_rd_valid_out(rd_v), .host_rd_data_out(rd_d), .host_rd_ready_in(rd_r),
        .in_overflow_out(ovf), .spi_sck_in(sck), .spi_mosi_in(mosi),
        .target_select_in(sel_n), .spi_miso_out(miso), .spi_miso_oe_out(oe),
        .i2c_scl_in(scl), .i2c_sda_in(sda), .i2c_sda_out(), .i2c_sda_oe_out(sda_oe),
        .uart_rx_in(utx), .uart_tx_out(utx));
    smsf_spi_master i_master (.sck_out(sck), .mosi_out(mosi), .select_n_out(sel_n),
        .miso_in(miso));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic idle(input int n);
        repeat (n) @(negedge clk_in);
    endtask : idle
    task automatic push(input logic [7:0] b);
        @(negedge clk_in);
        wr_v = 1'b1;
        wr_d = b;
        @(negedge clk_in);
        wr_v = 1'b0;
    endtask : push
    task automatic pop(input logic [7:0] exp);
        @(negedge clk_in);
        check({7'h00, rd_v}, 8'h01);
        check(rd_d, exp);
        rd_r = 1'b1;
        @(negedge clk_in);
        rd_r = 1'b0;
    endtask : pop
    task automatic frame(input logic [7:0] tx, input logic [7:0] exp);
        i_master.set_select(1'b1);
        i_master.xfer(tx, rx);
        i_master.set_select(1'b0);
        check(rx, exp);
    endtask : frame
    task automatic t_spi();
        push(8'h11);
        push(8'h22);
        idle(6);
        i_master.set_select(1'b1);
        check({7'h00, oe}, 8'h01);
        i_master.xfer(8'hA5, rx);
        check(rx, 8'h11);
        i_master.xfer(8'h3C, rx);
        check(rx, 8'h22);
        i_master.xfer(8'hF0, rx);
        check(rx, 8'h00);
        i_master.set_select(1'b0);
        check({7'h00, oe}, 8'h00);
        push(8'h33);
        idle(6);
        frame(8'h5A, 8'h33);
        idle(6);
        pop(8'hA5);
        pop(8'h3C);
        pop(8'hF0);
        pop(8'h5A);
        check({7'h00, rd_v}, 8'h00);
    endtask : t_spi
    task automatic t_clear();
        frame(8'h77, 8'h00);
        for (int i = 0; i < 9; i++)
            push(8'(i));
        idle(6);
        check({5'h00, ovf, wr_r, rd_v}, 8'h01);
        clr = 1'b1;
        idle(1);
        clr = 1'b0;
        idle(3);
        check({5'h00, ovf, wr_r, rd_v}, 8'h02);
        frame(8'h81, 8'h00);
        idle(6);
        frame(8'h82, 8'h00);
        idle(6);
        pop(8'h81);
        pop(8'h82);
    endtask : t_clear
    // start (stop = 0) or stop (stop = 1) condition, sda open drain
    task automatic i2c_cond(input logic stop);
        sda_m = 1'b0;
        idle(4);
        scl = stop;
        idle(4);
        sda_m = stop;
        idle(4);
    endtask : i2c_cond
    task automatic i2c_byte(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            sda_m = b[i];
            idle(4);
            scl = 1'b1;
            idle(4);
            s[i] = sda;
            scl = 1'b0;
        end
    endtask : i2c_byte
    task automatic t_mode();
        cfg.sel = smsf_pkg::SMSF_SEL_UART;
        i_master.set_select(1'b1);
        check({7'h00, oe}, 8'h00);
        i_master.set_select(1'b0);
        push(8'h6b);
        idle(9000);
        pop(8'h6b);
        cfg = '{smsf_pkg::SMSF_SEL_I2C, 1'b0, 7'h2a, 1'b0};
        push(8'hc3);
        i2c_cond(1'b0);
        i2c_byte({7'h15, 2'h1});
        check({7'h00, s[0]}, 8'h01);
        i2c_cond(1'b1);
        i2c_cond(1'b0);
        i2c_byte({7'h2a, 2'h1});
        check({7'h00, s[0]}, 8'h00);
        i2c_byte({8'h96, 1'h1});
        check({7'h00, s[0]}, 8'h00);
        i2c_cond(1'b1);
        pop(8'h96);
        i2c_cond(1'b0);
        i2c_byte({7'h2a, 2'h3});
        i2c_byte(9'h1fe);
        check(s[8:1], 8'hc3);
        i2c_byte(9'h1ff);
        check(s[8:1], 8'h00);
        i2c_cond(1'b1);
        cfg.sel = smsf_pkg::SMSF_SEL_SPI;
    endtask : t_mode
    task automatic t_full();
        cfg.read_full = 1'b1;
        i_master.set_select(1'b1);
        for (int i = 0; i < 63; i++)
            i_master.xfer(8'(i), rx);
        i_master.set_select(1'b0);
        idle(6);
        check({7'h00, rd_v}, 8'h00);
        frame(8'h3F, 8'h00);
        idle(6);
        for (int i = 0; i < 64; i++)
            pop(8'(i));
        check({7'h00, rd_v}, 8'h00);
    endtask : t_full
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        #1 rst = 1'b1;
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
        rst = 1'b0;
        idle(3);
        check({6'h00, wr_r, rd_v}, 8'h02);
        check({7'h00, oe}, 8'h00);
        t_spi();
        t_clear();
        t_mode();
        t_full();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
